//--- shared/fcs_pkg.sv
`default_nettype none
package fcs_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned T_ADDR_SETUP_NS = 20;
  localparam int unsigned T_WE_LOW_NS = 50;
  localparam int unsigned T_DATA_HOLD_NS = 20;
  localparam int unsigned T_READ_ACCESS_NS = 150;
  localparam int unsigned T_ERASE_WINDOW_US = 80;
  localparam int unsigned NS_PER_US = 1000;

  // least times round up, never below one cycle
  function automatic int unsigned ns_to_cyc_up(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned ADDR_SETUP_CYC = ns_to_cyc_up(T_ADDR_SETUP_NS);
  localparam int unsigned WE_LOW_CYC = ns_to_cyc_up(T_WE_LOW_NS);
  localparam int unsigned DATA_HOLD_CYC = ns_to_cyc_up(T_DATA_HOLD_NS);
  localparam int unsigned SYNC_LATENCY_CYC = 4;
  localparam int unsigned READ_CYC = ns_to_cyc_up(T_READ_ACCESS_NS) + SYNC_LATENCY_CYC;
  // longest time rounds down
  localparam int unsigned ERASE_WINDOW_CYC = (T_ERASE_WINDOW_US * NS_PER_US) / CLK_PERIOD_NS;
  // a queued sector write needs its whole write cycle, hold included, well inside the window
  localparam int unsigned ADD_GUARD_CYC = ADDR_SETUP_CYC + WE_LOW_CYC + DATA_HOLD_CYC + 4;

  // ****************************************
  // flash bus
  // ****************************************
  localparam int unsigned FLASH_AW = 19;
  localparam int unsigned FLASH_DW = 8;
  localparam int unsigned SECTOR_LSB = 16;
  localparam int unsigned SECTOR_W = 3;
  localparam logic [FLASH_AW-1:0] UNLOCK_ADDR_1 = 19'h05555;
  localparam logic [FLASH_AW-1:0] UNLOCK_ADDR_2 = 19'h02AAA;
  localparam logic [SECTOR_LSB-1:0] QUERY_LOW_ADDR = 16'h0002;
  localparam logic [FLASH_DW-1:0] UNLOCK_DATA_1 = 8'hAA;
  localparam logic [FLASH_DW-1:0] UNLOCK_DATA_2 = 8'h55;
  localparam logic [FLASH_DW-1:0] CMD_READ_RESET = 8'hF0;
  localparam logic [FLASH_DW-1:0] CMD_AUTOSELECT = 8'h90;
  localparam logic [FLASH_DW-1:0] CMD_PROGRAM = 8'hA0;
  localparam logic [FLASH_DW-1:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [FLASH_DW-1:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [FLASH_DW-1:0] CMD_SECTOR_ERASE = 8'h30;
  localparam int unsigned POLL_STATUS_BIT = 7;
  localparam int unsigned TIMEOUT_FAIL_BIT = 5;

  // ****************************************
  // register map
  // ****************************************
  localparam int unsigned APB_AW = 8;
  localparam logic [APB_AW-1:0] REG_CTRL = 8'h00;
  localparam logic [APB_AW-1:0] REG_ADDR = 8'h04;
  localparam logic [APB_AW-1:0] REG_WDATA = 8'h08;
  localparam logic [APB_AW-1:0] REG_STATUS = 8'h0C;
  localparam logic [APB_AW-1:0] REG_RDATA = 8'h10;
  localparam int unsigned CTRL_OP_LSB = 0;
  localparam int unsigned CTRL_OP_W = 3;
  localparam int unsigned CTRL_MORE_BIT = 3;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_DONE_BIT = 1;
  localparam int unsigned STAT_FAIL_BIT = 2;
  localparam int unsigned STAT_REJECT_BIT = 3;
  localparam int unsigned STAT_WINDOW_BIT = 4;

  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_RESET = 3'h1,
    OP_PROGRAM = 3'h2,
    OP_CHIP_ERASE = 3'h3,
    OP_SECTOR_ERASE = 3'h4,
    OP_ADD_SECTOR = 3'h5,
    OP_PROTECT_QUERY = 3'h6
  } fcs_op_t;

  typedef struct packed {
    logic [FLASH_AW-1:0] addr;
    logic cs_n;
    logic oe_n;
    logic we_n;
    logic [FLASH_DW-1:0] dq_out;
    logic dq_oe;
  } fcs_pins_t;

  typedef struct packed {
    logic [FLASH_AW-1:0] addr;
    logic [FLASH_DW-1:0] data;
  } fcs_word_t;

endpackage
`default_nettype wire

//--- rtl/fcs_sync3.sv
`default_nettype none
module fcs_sync3 #(
  parameter int unsigned W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] ff1_reg;
  logic [W-1:0] ff2_reg;
  logic [W-1:0] ff3_reg;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  // change counts once the second and third stage agree
  always_comb begin
    q_next = (ff2_reg == ff3_reg) ? ff3_reg : q_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ff1_reg <= '0;
      ff2_reg <= '0;
      ff3_reg <= '0;
      q_reg <= '0;
    end else begin
      ff1_reg <= d;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
      q_reg <= q_next;
    end
  end

  assign q = q_reg;

endmodule
`default_nettype wire

//--- rtl/fcs_flash_host.sv
// The APB slave port and the address map were chosen for this implementation.
`default_nettype none
module fcs_flash_host
  import fcs_pkg::*;
#(
  parameter int unsigned ERASE_WINDOW_CYCLES = ERASE_WINDOW_CYC,
  parameter int unsigned CNT_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output fcs_pins_t flash_out,
  input wire logic [FLASH_DW-1:0] flash_dq_in
);

  // ****************************************
  // types and helpers
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_W_SETUP = 3'h1,
    ST_W_PULSE = 3'h2,
    ST_W_HOLD = 3'h3,
    ST_DISPATCH = 3'h4,
    ST_R_WAIT = 3'h5,
    ST_CHECK = 3'h6,
    ST_WINDOW = 3'h7
  } fcs_state_t;

  function automatic logic [2:0] seq_len(input fcs_op_t op);
    case (op)
      OP_RESET: return 3'h3;
      OP_PROTECT_QUERY: return 3'h3;
      OP_PROGRAM: return 3'h4;
      OP_CHIP_ERASE: return 3'h6;
      OP_SECTOR_ERASE: return 3'h6;
      OP_ADD_SECTOR: return 3'h1;
      default: return 3'h0;
    endcase
  endfunction

  // address/data of write number step of the sequence for op
  function automatic fcs_word_t seq_word(input fcs_op_t op, input logic [2:0] step,
                                         input logic [FLASH_AW-1:0] a, input logic [FLASH_DW-1:0] d);
    fcs_word_t w;
    w = '{addr: UNLOCK_ADDR_1, data: UNLOCK_DATA_1};
    if (op == OP_ADD_SECTOR) begin
      w = '{addr: a, data: CMD_SECTOR_ERASE};
    end else begin
      case (step)
        3'h1: w = '{addr: UNLOCK_ADDR_2, data: UNLOCK_DATA_2};
        3'h2: begin
          case (op)
            OP_RESET: w.data = CMD_READ_RESET;
            OP_PROTECT_QUERY: w.data = CMD_AUTOSELECT;
            OP_PROGRAM: w.data = CMD_PROGRAM;
            default: w.data = CMD_ERASE_SETUP;
          endcase
        end
        3'h3: if (op == OP_PROGRAM) w = '{addr: a, data: d};
        3'h4: w = '{addr: UNLOCK_ADDR_2, data: UNLOCK_DATA_2};
        3'h5: begin
          if (op == OP_CHIP_ERASE) w.data = CMD_CHIP_ERASE;
          else w = '{addr: a, data: CMD_SECTOR_ERASE};
        end
        default: w = w;
      endcase
    end
    return w;
  endfunction

  // address and data stay put from setup through hold, past the rise of we_n
  function automatic fcs_pins_t pin_drive(input fcs_state_t st, input fcs_word_t w,
                                          input logic [FLASH_AW-1:0] ra);
    fcs_pins_t p;
    p = '{addr: '0, cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_out: '0, dq_oe: 1'b0};
    case (st)
      ST_W_SETUP, ST_W_PULSE, ST_W_HOLD: begin
        p.addr = w.addr;
        p.cs_n = 1'b0;
        p.we_n = (st != ST_W_PULSE);
        p.dq_out = w.data;
        p.dq_oe = 1'b1;
      end
      ST_R_WAIT: begin
        p.addr = ra;
        p.cs_n = 1'b0;
        p.oe_n = 1'b0;
      end
      default: p = p;
    endcase
    return p;
  endfunction

  function automatic logic cnt_last(input logic [CNT_W-1:0] c, input int unsigned n);
    return c == CNT_W'(n - 1);
  endfunction

  // ****************************************
  // apb slave
  // ****************************************
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic [FLASH_AW-1:0] addr_cfg_reg, addr_cfg_next;
  logic [FLASH_DW-1:0] wdata_cfg_reg, wdata_cfg_next;
  logic access;
  logic complete;
  logic ctrl_wr;
  logic mapped;
  logic [31:0] status_word;
  logic busy;
  logic done_reg, done_next;
  logic fail_reg, fail_next;
  logic reject_reg, reject_next;
  logic [FLASH_DW-1:0] rdata_reg, rdata_next;
  fcs_state_t state_reg, state_next;

  always_comb begin
    access = psel & penable;
    complete = access & pready_reg;
    mapped = (paddr == REG_CTRL) || (paddr == REG_ADDR) || (paddr == REG_WDATA) ||
             (paddr == REG_STATUS) || (paddr == REG_RDATA);
    ctrl_wr = complete & pwrite & (paddr == REG_CTRL);
    busy = (state_reg != ST_IDLE) && (state_reg != ST_WINDOW);
    status_word = '0;
    status_word[STAT_BUSY_BIT] = busy;
    status_word[STAT_DONE_BIT] = done_reg;
    status_word[STAT_FAIL_BIT] = fail_reg;
    status_word[STAT_REJECT_BIT] = reject_reg;
    status_word[STAT_WINDOW_BIT] = (state_reg == ST_WINDOW);
    pready_next = access & ~pready_reg;
    pslverr_next = 1'b0;
    prdata_next = '0;
    if (access & ~pready_reg) begin
      pslverr_next = ~mapped;
      case (paddr)
        REG_ADDR: prdata_next = 32'(addr_cfg_reg);
        REG_WDATA: prdata_next = 32'(wdata_cfg_reg);
        REG_STATUS: prdata_next = status_word;
        REG_RDATA: prdata_next = 32'(rdata_reg);
        default: prdata_next = '0;
      endcase
    end
    addr_cfg_next = addr_cfg_reg;
    wdata_cfg_next = wdata_cfg_reg;
    if (complete & pwrite & (paddr == REG_ADDR)) addr_cfg_next = pwdata[FLASH_AW-1:0];
    if (complete & pwrite & (paddr == REG_WDATA)) wdata_cfg_next = pwdata[FLASH_DW-1:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
      addr_cfg_reg <= '0;
      wdata_cfg_reg <= '0;
    end else begin
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
      addr_cfg_reg <= addr_cfg_next;
      wdata_cfg_reg <= wdata_cfg_next;
    end
  end

  // ****************************************
  // command sequencer
  // ****************************************
  fcs_op_t op_reg, op_next;
  fcs_op_t cmd_op;
  logic cmd_more;
  logic more_reg, more_next;
  logic recheck_reg, recheck_next;
  logic [2:0] step_reg, step_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [CNT_W-1:0] win_reg, win_next;
  logic [FLASH_AW-1:0] addr_reg, addr_next;
  logic [FLASH_DW-1:0] data_reg, data_next;
  logic [FLASH_AW-1:0] raddr_reg, raddr_next;
  logic [FLASH_DW-1:0] rbyte_reg, rbyte_next;
  fcs_pins_t pins_reg, pins_next;
  logic [FLASH_DW-1:0] dq_sync;
  logic poll_target;
  logic window_ok;

  fcs_sync3 #(.W(FLASH_DW)) u_dq_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(flash_dq_in),
    .q(dq_sync)
  );

  always_comb begin
    cmd_op = fcs_op_t'(pwdata[CTRL_OP_LSB +: CTRL_OP_W]);
    cmd_more = pwdata[CTRL_MORE_BIT];
    state_next = state_reg;
    op_next = op_reg;
    more_next = more_reg;
    recheck_next = recheck_reg;
    step_next = step_reg;
    cnt_next = cnt_reg + 1'b1;
    win_next = (state_reg == ST_WINDOW) ? win_reg + 1'b1 : '0;
    addr_next = addr_reg;
    data_next = data_reg;
    raddr_next = raddr_reg;
    rbyte_next = rbyte_reg;
    done_next = done_reg;
    fail_next = fail_reg;
    rdata_next = rdata_reg;
    reject_next = reject_reg | (ctrl_wr & busy);
    // program expects its own bit 7 back, erase expects one
    poll_target = (op_reg == OP_PROGRAM) ? data_reg[POLL_STATUS_BIT] : 1'b1;
    window_ok = (state_reg == ST_WINDOW) && (win_reg < CNT_W'(ERASE_WINDOW_CYCLES - ADD_GUARD_CYC));
    case (state_reg)
      ST_IDLE, ST_WINDOW: begin
        if (ctrl_wr) begin
          if ((cmd_op == OP_ADD_SECTOR) && !window_ok) begin
            reject_next = 1'b1;
          end else begin
            // any other command in the window abandons the queued erase
            op_next = cmd_op;
            more_next = cmd_more;
            addr_next = addr_cfg_reg;
            data_next = wdata_cfg_reg;
            step_next = '0;
            cnt_next = '0;
            recheck_next = 1'b0;
            done_next = 1'b0;
            fail_next = 1'b0;
            reject_next = 1'b0;
            state_next = (seq_len(cmd_op) == 3'h0) ? ST_DISPATCH : ST_W_SETUP;
          end
        end else if ((state_reg == ST_WINDOW) && (win_reg >= CNT_W'(ERASE_WINDOW_CYCLES))) begin
          raddr_next = addr_reg;
          cnt_next = '0;
          state_next = ST_R_WAIT;
        end
      end
      ST_W_SETUP: begin
        if (cnt_last(cnt_reg, ADDR_SETUP_CYC)) begin
          cnt_next = '0;
          state_next = ST_W_PULSE;
        end
      end
      ST_W_PULSE: begin
        if (cnt_last(cnt_reg, WE_LOW_CYC)) begin
          cnt_next = '0;
          state_next = ST_W_HOLD;
        end
      end
      ST_W_HOLD: begin
        if (cnt_last(cnt_reg, DATA_HOLD_CYC)) begin
          cnt_next = '0;
          if (3'(step_reg + 3'h1) == seq_len(op_reg)) begin
            state_next = ST_DISPATCH;
          end else begin
            step_next = 3'(step_reg + 3'h1);
            state_next = ST_W_SETUP;
          end
        end
      end
      ST_DISPATCH: begin
        cnt_next = '0;
        raddr_next = addr_reg;
        case (op_reg)
          OP_RESET: begin
            done_next = 1'b1;
            state_next = ST_IDLE;
          end
          OP_PROTECT_QUERY: begin
            raddr_next = {addr_reg[FLASH_AW-1:SECTOR_LSB], QUERY_LOW_ADDR};
            state_next = ST_R_WAIT;
          end
          OP_SECTOR_ERASE, OP_ADD_SECTOR: state_next = more_reg ? ST_WINDOW : ST_R_WAIT;
          default: state_next = ST_R_WAIT;
        endcase
      end
      ST_R_WAIT: begin
        if (cnt_last(cnt_reg, READ_CYC)) begin
          rbyte_next = dq_sync;
          state_next = ST_CHECK;
        end
      end
      ST_CHECK: begin
        cnt_next = '0;
        case (op_reg)
          OP_READ: begin
            rdata_next = rbyte_reg;
            done_next = 1'b1;
            state_next = ST_IDLE;
          end
          OP_PROTECT_QUERY: begin
            // bit 0 set: protected; whole byte zero: unprotected
            rdata_next = rbyte_reg;
            op_next = OP_RESET;
            step_next = '0;
            state_next = ST_W_SETUP;
          end
          default: begin
            if (rbyte_reg[POLL_STATUS_BIT] == poll_target) begin
              rdata_next = rbyte_reg;
              done_next = 1'b1;
              state_next = ST_IDLE;
            end else if (recheck_reg) begin
              // bit 7 rechecked after bit 5 rose and still wrong
              fail_next = 1'b1;
              rdata_next = rbyte_reg;
              op_next = OP_RESET;
              step_next = '0;
              state_next = ST_W_SETUP;
            end else begin
              recheck_next = rbyte_reg[TIMEOUT_FAIL_BIT];
              state_next = ST_R_WAIT;
            end
          end
        endcase
      end
      default: state_next = ST_IDLE;
    endcase
    pins_next = pin_drive(state_next, seq_word(op_next, step_next, addr_next, data_next), raddr_next);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      op_reg <= OP_READ;
      more_reg <= 1'b0;
      recheck_reg <= 1'b0;
      step_reg <= '0;
      cnt_reg <= '0;
      win_reg <= '0;
      addr_reg <= '0;
      data_reg <= '0;
      raddr_reg <= '0;
      rbyte_reg <= '0;
      done_reg <= 1'b0;
      fail_reg <= 1'b0;
      reject_reg <= 1'b0;
      rdata_reg <= '0;
      pins_reg <= '{addr: '0, cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_out: '0, dq_oe: 1'b0};
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      more_reg <= more_next;
      recheck_reg <= recheck_next;
      step_reg <= step_next;
      cnt_reg <= cnt_next;
      win_reg <= win_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      raddr_reg <= raddr_next;
      rbyte_reg <= rbyte_next;
      done_reg <= done_next;
      fail_reg <= fail_next;
      reject_reg <= reject_next;
      rdata_reg <= rdata_next;
      pins_reg <= pins_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign flash_out = pins_reg;

endmodule
`default_nettype wire

//--- test/fcs_host_chk.sv
`default_nettype none
module fcs_host_chk
  import fcs_pkg::*;
#(
  parameter int unsigned ERASE_WINDOW_CYCLES = ERASE_WINDOW_CYC,
  parameter int unsigned CNT_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire fcs_pins_t flash_out,
  input wire logic [FLASH_DW-1:0] flash_dq_in
);
  // ****************************************
  // bus and strobe properties
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not in second access cycle");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  write_sel_a: assert property (!flash_out.we_n |-> !flash_out.cs_n && flash_out.oe_n && flash_out.dq_oe)
    else $error("write strobe without select or drive");
  strobe_width_a: assert property ($fell(flash_out.we_n) |-> !flash_out.we_n [*5] ##1
    !flash_out.we_n [*5] ##1 flash_out.we_n)
    else $error("write strobe low width wrong");
  write_stable_a: assert property (!flash_out.we_n |=> $stable(flash_out.addr) && $stable(flash_out.dq_out))
    else $error("address or data moved in write");
  data_hold_a: assert property ($rose(flash_out.we_n) |-> flash_out.dq_oe [*4])
    else $error("data released before hold time");
  read_quiet_a: assert property (!flash_out.oe_n |-> !flash_out.cs_n && flash_out.we_n && !flash_out.dq_oe)
    else $error("read cycle with host drive");
  poll_addr_a: assert property (!flash_out.oe_n && $past(!flash_out.oe_n) |-> $stable(flash_out.addr))
    else $error("address moved during read");
  unlock_addr_a: assert property ($fell(flash_out.we_n) && flash_out.dq_out == UNLOCK_DATA_2
    |-> flash_out.addr == UNLOCK_ADDR_2)
    else $error("second unlock at wrong address");
endmodule
bind fcs_flash_host fcs_host_chk #(.ERASE_WINDOW_CYCLES(ERASE_WINDOW_CYCLES), .CNT_W(CNT_W)) chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_out(flash_out),
  .flash_dq_in(flash_dq_in));
`default_nettype wire

//--- test/fcs_flash_model.sv
`default_nettype none
module fcs_flash_model
  import fcs_pkg::*;
#(
  parameter int unsigned WIN_NS = 1000
) (
  input wire fcs_pins_t pins,
  output logic [FLASH_DW-1:0] dq
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // behavioural flash array
  // ****************************************
  logic [FLASH_DW-1:0] mem [0:(1<<FLASH_AW)-1];
  logic [7:0] prot = 8'h00;
  logic [7:0] emask = 8'h00;
  logic [FLASH_DW-1:0] rd_val = 8'h00;
  logic [FLASH_DW-1:0] pd = 8'h00;
  logic [FLASH_AW-1:0] a_lat;
  logic fail_en = 1'b0;
  logic failed = 1'b0;
  logic prog = 1'b0;
  logic auto_q = 1'b0;
  logic win = 1'b0;
  logic tog = 1'b0;
  logic susp = 1'b0;
  int step = 0;
  int busy_n = 0;
  int busy_cfg = 0;
  time t_last = 0;

  initial foreach (mem[i]) mem[i] = 8'hFF;

  task automatic erase_sec(input int s);
    if (!prot[s]) for (int i = 0; i < 65536; i++) mem[s*65536+i] = 8'hFF;
  endtask

  task automatic take(input logic [FLASH_AW-1:0] a, input logic [7:0] d);
    logic [14:0] c;
    c = a[14:0];
    if (!prog && (win || busy_n > 0) && d inside {8'hB0, CMD_SECTOR_ERASE}) susp = (d == 8'hB0);
    if (busy_n > 0 && !failed) return;
    if (win && step == 0 && d == CMD_SECTOR_ERASE) emask[a[18:16]] = 1'b1;
    else if (step inside {0, 4} && c == 15'h5555 && d == UNLOCK_DATA_1) begin
      step++;
      win = 1'b0;
    end
    else if (step inside {1, 5} && c == 15'h2AAA && d == UNLOCK_DATA_2) step++;
    else if (step == 2 && c == 15'h5555) begin
      step = (d == CMD_PROGRAM) ? 3 : (d == CMD_ERASE_SETUP) ? 4 : 0;
      if (d == CMD_AUTOSELECT) auto_q = 1'b1;
      if (d == CMD_READ_RESET) begin
        auto_q = 1'b0;
        failed = 1'b0;
        busy_n = 0;
      end
    end
    else if (step == 3) begin
      step = 0;
      pd = d;
      prog = 1'b1;
      failed = fail_en;
      busy_n = fail_en ? 1 : busy_cfg;
      if (!prot[a[18:16]] && !fail_en) mem[a] = d;
    end
    else if (step == 6 && c == 15'h5555 && d == CMD_CHIP_ERASE) begin
      step = 0;
      prog = 1'b0;
      busy_n = busy_cfg;
      for (int s = 0; s < 8; s++) erase_sec(s);
    end
    else if (step == 6 && d == CMD_SECTOR_ERASE) begin
      step = 0;
      win = 1'b1;
      emask = 8'h00;
      emask[a[18:16]] = 1'b1;
    end
    else begin
      step = 0;
      win = 1'b0;
    end
  endtask

  always @(negedge pins.we_n) a_lat = pins.addr;
  always @(posedge pins.we_n) begin
    t_last = $time;
    if (pins.cs_n === 1'b0) take(a_lat, pins.dq_out);
  end

  always begin
    #5;
    if (win && pins.we_n === 1'b1 && $time - t_last >= WIN_NS) begin
      win = 1'b0;
      prog = 1'b0;
      busy_n = busy_cfg;
      for (int s = 0; s < 8; s++) if (emask[s]) erase_sec(s);
    end
  end

  always @(negedge pins.oe_n) if (pins.cs_n === 1'b0) begin
    tog = ~tog;
    if ((win || busy_n > 0) && !(susp && !emask[pins.addr[18:16]])) begin
      rd_val = {prog ? ~pd[7] : 1'b0, tog, failed, 5'h00};
      if (!failed && !win) busy_n--;
    end
    else if (auto_q) rd_val = {7'h00, !pins.addr[6] && pins.addr[1:0] == 2'b10 && prot[pins.addr[18:16]]};
    else rd_val = mem[pins.addr];
  end
  // released bus shows the inverse of the last byte
  assign dq = (!pins.cs_n && !pins.oe_n) ? rd_val : ~rd_val;
endmodule
`default_nettype wire

//--- test/fcs_flash_host_tb_top.sv
`default_nettype none
module fcs_flash_host_tb_top
  import fcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // harness
  // ****************************************
  localparam int unsigned WIN = 200;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  fcs_pins_t fo;
  logic [FLASH_DW-1:0] fdq;
  wire [FLASH_DW-1:0] dq_in;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  logic [31:0] r;
  logic e;
  assign dq_in = fo.dq_oe ? fo.dq_out : fdq;

  fcs_flash_host #(.ERASE_WINDOW_CYCLES(WIN)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flash_out(fo), .flash_dq_in(dq_in));
  fcs_flash_model #(.WIN_NS(WIN * CLK_PERIOD_NS)) FM (.pins(fo), .dq(fdq));

  initial forever #2.5 pclk = ~pclk;

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wait_done(input logic win_too);
    do apb(1'b0, REG_STATUS, 32'h0); while (r[STAT_BUSY_BIT] !== 1'b0 || (win_too && r[STAT_WINDOW_BIT] !== 1'b0));
  endtask

  task automatic op(input fcs_op_t o, input logic more, input logic [18:0] a, input logic [7:0] d);
    apb(1'b1, REG_ADDR, {13'h0, a});
    apb(1'b1, REG_WDATA, {24'h0, d});
    apb(1'b1, REG_CTRL, {28'h0, more, o});
    if (!more) wait_done(1'b1);
  endtask

  task automatic read_at(input logic [18:0] a, input logic [7:0] exp, input string what);
    op(OP_READ, 1'b0, a, 8'h00);
    apb(1'b0, REG_RDATA, 32'h0);
    check(what, r, {24'h0, exp});
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    FM.mem[19'h12345] = 8'h3C;
    FM.mem[19'h10005] = 8'h11;
    FM.mem[19'h30007] = 8'h22;
    FM.mem[19'h50001] = 8'h33;
    FM.mem[19'h20020] = 8'h44;
    @(posedge pclk);
    apb(1'b0, REG_STATUS, 32'h0);
    check("status after reset", r, 32'h0);
    read_at(19'h12345, 8'h3C, "power-up read");
    apb(1'b0, 8'h14, 32'h0);
    check("unmapped error", {31'h0, e}, 32'h1);
    apb(1'b1, REG_ADDR, 32'hFFFFFFFF);
    apb(1'b0, REG_ADDR, 32'h0);
    check("addr register", r, 32'h0007FFFF);
    $display("test registers done");
    FM.busy_cfg = 3;
    op(OP_PROGRAM, 1'b0, 19'h7FFFF, 8'h5A);
    apb(1'b0, REG_STATUS, 32'h0);
    check("program status", r, 32'h2);
    op(OP_PROGRAM, 1'b0, 19'h00000, 8'hC3);
    read_at(19'h7FFFF, 8'h5A, "programmed top");
    read_at(19'h00000, 8'hC3, "programmed bottom");
    $display("test program done");
    FM.prot = 8'h04;
    op(OP_PROTECT_QUERY, 1'b0, 19'h20000, 8'h00);
    apb(1'b0, REG_RDATA, 32'h0);
    check("protected query", r, 32'h1);
    op(OP_PROTECT_QUERY, 1'b0, 19'h30000, 8'h00);
    apb(1'b0, REG_RDATA, 32'h0);
    check("unprotected query", r, 32'h0);
    read_at(19'h12345, 8'h3C, "read after query");
    op(OP_PROGRAM, 1'b0, 19'h20010, 8'h80);
    read_at(19'h20010, 8'hFF, "protected program");
    $display("test protection done");
    op(OP_SECTOR_ERASE, 1'b1, 19'h10000, 8'h00);
    wait_done(1'b0);
    check("window open", {31'h0, r[STAT_WINDOW_BIT]}, 32'h1);
    op(OP_ADD_SECTOR, 1'b1, 19'h3FFFF, 8'h00);
    wait_done(1'b1);
    read_at(19'h10005, 8'hFF, "erased first");
    read_at(19'h30007, 8'hFF, "erased added");
    read_at(19'h50001, 8'h33, "unselected kept");
    op(OP_ADD_SECTOR, 1'b1, 19'h40000, 8'h00);
    apb(1'b0, REG_STATUS, 32'h0);
    check("late add rejected", {31'h0, r[STAT_REJECT_BIT]}, 32'h1);
    op(OP_SECTOR_ERASE, 1'b1, 19'h50000, 8'h00);
    wait_done(1'b0);
    op(OP_RESET, 1'b0, 19'h00000, 8'h00);
    repeat (2 * WIN) @(posedge pclk);
    read_at(19'h50001, 8'h33, "aborted erase");
    op(OP_SECTOR_ERASE, 1'b0, 19'h7FFFF, 8'h00);
    read_at(19'h7FFFF, 8'hFF, "erased at once");
    $display("test sector erase done");
    op(OP_CHIP_ERASE, 1'b0, 19'h00000, 8'h00);
    read_at(19'h50001, 8'hFF, "chip erased");
    read_at(19'h20020, 8'h44, "protected kept");
    $display("test chip erase done");
    FM.fail_en = 1'b1;
    op(OP_PROGRAM, 1'b0, 19'h60000, 8'h12);
    apb(1'b0, REG_STATUS, 32'h0);
    check("timeout status", r & 32'h6, 32'h6);
    FM.fail_en = 1'b0;
    read_at(19'h60000, 8'hFF, "read after failure");
    $display("test failure done");
    report_and_stop();
  end
endmodule
`default_nettype wire
